// *** design/vwsp_slave.v ***
// Variable-width serial slave port with its write-data FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "vwsp_map.vh"

module vwsp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `VWSP_FIFO_DEPTH,
    parameter AW = 2
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_ff, rp_ff;
    reg [AW:0] cnt_ff;
    wire push, pop;

    assign in_ready = (cnt_ff != DEPTH[AW:0]);
    assign out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign out_data = mem[rp_ff];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wp_ff] <= in_data;
        end
    end

    // Pointers wrap by index so a depth that is not a power of two still works.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff <= {AW{1'b0}};
            rp_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_ff <= (wp_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= (rp_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule // vwsp_fifo

module vwsp_slave #(
    parameter FIFO_DEPTH = `VWSP_FIFO_DEPTH,
    parameter FIFO_AW = 2
) (
    input wire core_clk,
    input wire rst_n,
    input wire sclk,
    input wire ss_n,
    input wire [7:0] data_in,
    output wire [7:0] data_out,
    output wire [7:0] data_oe,
    output wire miso_out,
    output wire miso_oe,
    input wire cfg_cpol,
    input wire cfg_lsb_first,
    input wire cfg_status_en,
    input wire rd_valid,
    input wire [7:0] rd_data,
    output wire rd_ready,
    output wire wr_valid,
    output wire [7:0] wr_data,
    input wire wr_ready,
    input wire modem_rts,
    input wire modem_dtr,
    output wire [3:0] modem_status,
    output wire flush_req,
    output wire [7:0] nv_addr,
    output wire [7:0] nv_wr_data,
    output wire nv_wr_strobe,
    input wire [7:0] nv_rd_data,
    input wire [1:0] usb_state
);
    localparam PH_CMD = 1'b0, PH_DATA = 1'b1;
    // Shift amount of beat idx inside a byte for the given width and bit order.
    function [3:0] beat_shift;
        input [2:0] idx;
        input [1:0] ws;
        input lsb;
        reg [7:0] w;
        reg [7:0] lo;
        begin
            w = 8'h01 << ws;
            lo = w * {5'h00, idx};
            beat_shift = lsb ? lo[3:0] : 4'h8 - lo[3:0] - w[3:0];
        end
    endfunction

    function [7:0] width_mask;
        input [1:0] ws;
        reg [8:0] m;
        begin
            m = (9'h001 << (9'h001 << ws)) - 9'h001;
            width_mask = m[7:0];
        end
    endfunction

    // Two flip-flops on every pin input; the third clock stage only finds edges.
    reg [1:0] sclk_sy_ff, ss_sy_ff;
    reg sclk_d_ff, ss_d_ff;
    reg [7:0] din_s1_ff, din_s2_ff;
    reg ph_ff, odd_ff, ack_ff, drv_ff, miso_ff, miso_oe_ff;
    reg flush_ff, nv_stb_ff, push_ff;
    reg [1:0] ws_ff;
    reg [2:0] beat_ff;
    reg [3:0] cmd_ff, mdm_ff;
    reg [7:0] byte_ff, rx_ff, dout_ff, doe_ff;
    reg [7:0] nv_addr_ff, nv_data_ff, push_data_ff;
    wire ss_act, sclk_edge, edge_drive, edge_sample, first_ok;
    wire is_rd_cmd, tx_avail, last_beat, fifo_in_ready;
    wire [1:0] cmd_ws;
    wire [3:0] cmd_code;
    wire [7:0] cb, tx_src, tx_byte, beat_val, rx_next;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sy_ff <= 2'h0;
            sclk_d_ff <= 1'b0;
            ss_sy_ff <= 2'h3;
            ss_d_ff <= 1'b1;
            din_s1_ff <= 8'hff;
            din_s2_ff <= 8'hff;
        end else begin
            sclk_sy_ff <= {sclk_sy_ff[0], sclk};
            sclk_d_ff <= sclk_sy_ff[1];
            ss_sy_ff <= {ss_sy_ff[0], ss_n};
            ss_d_ff <= ss_sy_ff[1];
            din_s1_ff <= data_in;
            din_s2_ff <= din_s1_ff;
        end
    end

    assign ss_act = ~ss_sy_ff[1];
    // Both clock directions count; the first edge after select must leave the
    // idle level, so a clock parked at the wrong polarity is not miscounted.
    assign first_ok = (ph_ff == PH_DATA) | odd_ff | (sclk_d_ff == cfg_cpol);
    assign sclk_edge = ss_act & ~ss_d_ff & first_ok & (sclk_sy_ff[1] ^ sclk_d_ff);
    assign edge_drive = sclk_edge & ~odd_ff;
    assign edge_sample = sclk_edge & odd_ff;
    // Command beat fields: width from lines 7 to 1, where a low code line 6, 5 or 3 also widens it; code from lines 6, 5, 3 and 0.
    assign cb = din_s2_ff;
    assign cmd_ws = (~&cb[7:4]) ? `VWSP_WID_8 :
                    (~&cb[3:2]) ? `VWSP_WID_4 :
                    (~cb[`VWSP_CB_W2]) ? `VWSP_WID_2 : `VWSP_WID_1;
    assign cmd_code = {cb[`VWSP_CB_CMD3], cb[`VWSP_CB_CMD2],
                       cb[`VWSP_CB_CMD1], cb[`VWSP_CB_CMD0]};

    assign is_rd_cmd = (cmd_ff == `VWSP_CMD_READ) || (cmd_ff == `VWSP_CMD_MDM_RD) ||
                       (cmd_ff == `VWSP_CMD_NV_RD) || (cmd_ff == `VWSP_CMD_USB_ST);

    reg nxt_avail;
    reg [7:0] nxt_src;
    always @* begin
        nxt_avail = 1'b1;
        nxt_src = 8'hff;
        case (cmd_ff)
            `VWSP_CMD_WRITE: begin
                nxt_avail = fifo_in_ready;
            end
            `VWSP_CMD_READ: begin
                nxt_avail = rd_valid;
                nxt_src = rd_data;
            end
            `VWSP_CMD_MDM_RD: begin
                nxt_src = {6'h00, modem_dtr, modem_rts};
            end
            `VWSP_CMD_NV_RD: begin
                nxt_src = nv_rd_data;
            end
            `VWSP_CMD_USB_ST: begin
                nxt_src = {6'h00, usb_state};
            end
            `VWSP_CMD_MDM_WR, `VWSP_CMD_FLUSH, `VWSP_CMD_NV_ADDR, `VWSP_CMD_NV_WR: begin
                nxt_avail = 1'b1;
            end
            default: begin
                nxt_avail = 1'b0;
            end
        endcase
    end
    assign tx_avail = nxt_avail;
    assign tx_src = nxt_src;

    // A new byte starts on the drive edge of beat zero; later beats reuse it.
    assign tx_byte = (beat_ff == 3'h0) ? tx_src : byte_ff;
    assign beat_val = (tx_byte >> beat_shift(beat_ff, ws_ff, cfg_lsb_first))
                      & width_mask(ws_ff);
    assign last_beat = (beat_ff == (3'h7 >> ws_ff));
    assign rx_next = ((beat_ff == 3'h0) ? 8'h00 : rx_ff) |
                     ((din_s2_ff & width_mask(ws_ff))
                      << beat_shift(beat_ff, ws_ff, cfg_lsb_first));

    // The byte counts as moved on its last sample edge, so a master that
    // quits mid-byte leaves buffers and memory as they were.
    assign rd_ready = ss_act & (ph_ff == PH_DATA) & edge_sample & last_beat &
                      (cmd_ff == `VWSP_CMD_READ) & (ack_ff == `VWSP_ACK);

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_ff <= PH_CMD;
            odd_ff <= 1'b0;
            ws_ff <= `VWSP_WID_1;
            cmd_ff <= 4'hf;
            beat_ff <= 3'h0;
            byte_ff <= 8'h00;
            rx_ff <= 8'h00;
            ack_ff <= `VWSP_NAK;
            drv_ff <= 1'b0;
            mdm_ff <= `VWSP_MDM_RST;
            flush_ff <= 1'b0;
            nv_addr_ff <= `VWSP_NV_ADDR_RST;
            nv_data_ff <= 8'h00;
            nv_stb_ff <= 1'b0;
            push_ff <= 1'b0;
            push_data_ff <= 8'h00;
        end else begin
            flush_ff <= 1'b0;
            nv_stb_ff <= 1'b0;
            push_ff <= 1'b0;
            if (!ss_act) begin
                ph_ff <= PH_CMD;
                odd_ff <= 1'b0;
                beat_ff <= 3'h0;
                drv_ff <= 1'b0;
            end else if (sclk_edge) begin
                odd_ff <= ~odd_ff;
                if (ph_ff == PH_CMD) begin
                    if (edge_sample) begin
                        ph_ff <= PH_DATA;
                        ws_ff <= cmd_ws;
                        cmd_ff <= cmd_code;
                        beat_ff <= 3'h0;
                        flush_ff <= (cmd_code == `VWSP_CMD_FLUSH);
                    end
                end else if (edge_drive) begin
                    drv_ff <= is_rd_cmd;
                    if (beat_ff == 3'h0) begin
                        byte_ff <= tx_src;
                        ack_ff <= tx_avail ? `VWSP_ACK : `VWSP_NAK;
                    end
                end else begin
                    rx_ff <= rx_next;
                    beat_ff <= last_beat ? 3'h0 : beat_ff + 3'h1;
                    if (last_beat && ack_ff == `VWSP_ACK) begin
                        case (cmd_ff)
                            `VWSP_CMD_WRITE: begin
                                push_ff <= 1'b1;
                                push_data_ff <= rx_next;
                            end
                            `VWSP_CMD_MDM_WR: begin
                                mdm_ff <= rx_next[3:0];
                            end
                            `VWSP_CMD_NV_ADDR: begin
                                nv_addr_ff <= rx_next;
                            end
                            `VWSP_CMD_NV_WR: begin
                                nv_data_ff <= rx_next;
                                nv_stb_ff <= 1'b1;
                            end
                            default: begin
                                mdm_ff <= mdm_ff;
                            end
                        endcase
                    end
                end
            end
        end
    end

    // Pin drivers are registered; idle status is withdrawn as soon as select
    // is seen, and data only returns at the first drive edge after the
    // turnaround.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_ff <= 8'h00;
            doe_ff <= 8'h00;
            miso_ff <= 1'b0;
            miso_oe_ff <= 1'b0;
        end else if (!ss_act) begin
            dout_ff <= {7'h00, fifo_in_ready};
            doe_ff <= {7'h00, cfg_status_en};
            miso_ff <= rd_valid;
            miso_oe_ff <= cfg_status_en;
        end else if (ss_act && !ss_d_ff && ss_sy_ff[1] == 1'b0 && ph_ff == PH_CMD) begin
            doe_ff <= 8'h00;
            miso_oe_ff <= 1'b1;
            miso_ff <= `VWSP_ACK;
        end else if (edge_drive && ph_ff == PH_DATA) begin
            dout_ff <= beat_val;
            doe_ff <= is_rd_cmd ? width_mask(ws_ff) : 8'h00;
            if (beat_ff == 3'h0) begin
                miso_ff <= tx_avail ? `VWSP_ACK : `VWSP_NAK;
            end
        end else if (ss_act && ss_d_ff) begin
            doe_ff <= 8'h00;
            miso_oe_ff <= 1'b1;
        end
    end

    vwsp_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_wr_fifo (
        .clk(core_clk),
        .rst_n(rst_n),
        .in_valid(push_ff),
        .in_ready(fifo_in_ready),
        .in_data(push_data_ff),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_data)
    );

    assign data_out = dout_ff;
    assign data_oe = drv_ff | ~ss_act ? doe_ff : 8'h00;
    assign miso_out = miso_ff;
    assign miso_oe = miso_oe_ff;
    assign modem_status = mdm_ff;
    assign flush_req = flush_ff;
    assign nv_addr = nv_addr_ff;
    assign nv_wr_data = nv_data_ff;
    assign nv_wr_strobe = nv_stb_ff;
endmodule // vwsp_slave

`default_nettype wire

// *** design/vwsp_map.vh ***
// Command codes, width codes and reset values of the variable-width slave port.
`ifndef VWSP_MAP_VH
`define VWSP_MAP_VH

`define VWSP_CMD_WRITE 4'h0
`define VWSP_CMD_READ 4'h1
`define VWSP_CMD_MDM_RD 4'h2
`define VWSP_CMD_MDM_WR 4'h3
`define VWSP_CMD_FLUSH 4'h4
`define VWSP_CMD_NV_ADDR 4'h5
`define VWSP_CMD_NV_WR 4'h6
`define VWSP_CMD_NV_RD 4'h7
`define VWSP_CMD_USB_ST 4'h8
`define VWSP_CMD_LAST 4'h8

`define VWSP_WID_1 2'h0
`define VWSP_WID_2 2'h1
`define VWSP_WID_4 2'h2
`define VWSP_WID_8 2'h3

`define VWSP_CB_CMD3 0
`define VWSP_CB_W2 1
`define VWSP_CB_W4_LO 2
`define VWSP_CB_CMD2 3
`define VWSP_CB_W8_LO 4
`define VWSP_CB_CMD1 5
`define VWSP_CB_CMD0 6

`define VWSP_ACK 1'h0
`define VWSP_NAK 1'h1
`define VWSP_FIFO_DEPTH 4
`define VWSP_MDM_RST 4'h0
`define VWSP_NV_ADDR_RST 8'h00

`endif

// *** verification/vwsp_master.sv ***
// Behavioural bus master that drives the serial clock, select and data lines.
`timescale 1ns/1ps
`default_nettype none
module vwsp_master (
    output var logic sclk,
    output var logic ss_n,
    output wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    input wire logic miso_out,
    input wire logic cpol,
    input wire logic lsb
);
    localparam int HALF = 160;
    logic m_oe;
    logic [7:0] m_d;
    logic [7:0] txb [8];
    logic [7:0] rxb [8];
    logic akb [8];
    // Lines that nobody drives read high through their pull-ups.
    assign data_in = (data_oe & data_out) | (~data_oe & (m_oe ? m_d : 8'hff));
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        m_oe = 1'b0;
        m_d = 8'hff;
    end
    task automatic xfer(input logic [3:0] c, input int w, input int n, input bit rd);
        int nb;
        int j;
        logic [7:0] msk;
        nb = 8 / w;
        msk = 8'((1 << w) - 1);
        m_d = {1'b1, c[0], c[1], w != 8, c[2], w != 4, w != 2, c[3]};
        sclk = cpol;
        #(HALF) ss_n = 1'b0;
        #(2 * HALF) sclk = ~sclk;
        m_oe = 1'b1;
        #(HALF) sclk = ~sclk;
        for (int b = 0; b < n; b++) begin
            rxb[b] = 8'h00;
            for (int k = 0; k < nb; k++) begin
                j = lsb ? k * w : (nb - 1 - k) * w;
                #(HALF) sclk = ~sclk;
                m_oe = !rd;
                m_d = ~msk | ((txb[b] >> j) & msk);
                #(HALF);
                if (k == 0) akb[b] = miso_out;
                rxb[b] = rxb[b] | ((data_in & msk) << j);
                sclk = ~sclk;
            end
            if (akb[b]) break;
        end
        #(HALF) ss_n = 1'b1;
        m_oe = 1'b0;
        #(4 * HALF);
    endtask
endmodule // vwsp_master
`default_nettype wire

// *** verification/vwsp_slave_chk.sv ***
// Concurrent checks on the ports of the slave port.
`timescale 1ns/1ps
`default_nettype none
module vwsp_slave_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic [7:0] data_oe,
    input wire logic miso_oe,
    input wire logic cfg_status_en,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic wr_ready,
    input wire logic [3:0] modem_status,
    input wire logic flush_req,
    input wire logic [7:0] nv_wr_data,
    input wire logic nv_wr_strobe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_idle_on;
        (ss_n && cfg_status_en) [*8] |-> data_oe == 8'h01 && miso_oe;
    endproperty
    a_idle_on: assert property (p_idle_on) else $error("idle status missing");
    property p_idle_off;
        (ss_n && !cfg_status_en) [*8] |-> data_oe == 8'h00 && !miso_oe;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("idle lines driven");
    property p_turn;
        $fell(ss_n) ##1 (!ss_n && $stable(sclk)) [*7] |-> data_oe == 8'h00;
    endproperty
    a_turn: assert property (p_turn) else $error("lines driven before first edge");
    property p_miso;
        !ss_n [*8] |-> miso_oe;
    endproperty
    a_miso: assert property (p_miso) else $error("status line not driven");
    property p_flush;
        flush_req |=> !flush_req;
    endproperty
    a_flush: assert property (p_flush) else $error("flush pulse too long");
    property p_nv_wr;
        nv_wr_strobe |=> !nv_wr_strobe && $stable(nv_wr_data);
    endproperty
    a_nv_wr: assert property (p_nv_wr) else $error("store pulse wrong");
    property p_nv_data;
        $changed(nv_wr_data) |-> nv_wr_strobe;
    endproperty
    a_nv_data: assert property (p_nv_data) else $error("store data without pulse");
    property p_modem;
        $changed(modem_status) |-> !$past(ss_n, 6);
    endproperty
    a_modem: assert property (p_modem) else $error("modem bits changed idle");
    property p_rd;
        rd_ready |-> rd_valid ##1 !rd_ready;
    endproperty
    a_rd: assert property (p_rd) else $error("read take wrong");
    property p_wr_hold;
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_data);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write data not held");
endmodule // vwsp_slave_chk
bind vwsp_slave vwsp_slave_chk u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .ss_n(ss_n), .data_oe(data_oe),
    .miso_oe(miso_oe), .cfg_status_en(cfg_status_en), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .modem_status(modem_status), .flush_req(flush_req), .nv_wr_data(nv_wr_data),
    .nv_wr_strobe(nv_wr_strobe));
`default_nettype wire

// *** verification/vwsp_slave_bench.sv ***
// Self-checking bench for the variable-width slave port.
`timescale 1ns/1ps
`default_nettype none
module vwsp_slave_bench;
    logic core_clk, rst_n, cfg_cpol, cfg_lsb_first, cfg_status_en;
    logic rd_valid, wr_ready, modem_rts, modem_dtr;
    logic [7:0] rd_data;
    logic [1:0] usb_state;
    wire logic sclk, ss_n, miso_out, miso_oe, rd_ready, wr_valid, flush_req, nv_wr_strobe;
    wire logic [7:0] data_in, data_out, data_oe, wr_data, nv_addr, nv_wr_data, nv_rd_data;
    wire logic [3:0] modem_status;
    int total_checks = 0, miscompares = 0, n_fl = 0, n_nv = 0, n_rd = 0;
    assign nv_rd_data = ~nv_addr;
    vwsp_slave u_dut (.core_clk, .rst_n, .sclk, .ss_n, .data_in, .data_out, .data_oe,
        .miso_out, .miso_oe, .cfg_cpol, .cfg_lsb_first, .cfg_status_en, .rd_valid,
        .rd_data, .rd_ready, .wr_valid, .wr_data, .wr_ready, .modem_rts, .modem_dtr,
        .modem_status, .flush_req, .nv_addr, .nv_wr_data, .nv_wr_strobe, .nv_rd_data,
        .usb_state);
    vwsp_master u_mst (.sclk, .ss_n, .data_in, .data_out, .data_oe, .miso_out,
        .cpol(cfg_cpol), .lsb(cfg_lsb_first));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (flush_req === 1'b1) n_fl++;
        if (nv_wr_strobe === 1'b1) n_nv++;
        if (rd_ready === 1'b1) n_rd++;
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic got(input logic [7:0] d, input logic a);
        chk(u_mst.rxb[0], d);
        chk(8'(u_mst.akb[0]), 8'(a));
    endtask
    // Pops one word; waits at least one edge so wr_ready never toggles twice at once.
    task automatic pop(input logic [7:0] e);
        int i;
        i = 0;
        do begin
            @(posedge core_clk);
            #2 i++;
        end while (wr_valid !== 1'b1 && i < 50);
        chk(wr_data, e);
        wr_ready = 1'b1;
        @(posedge core_clk);
        #2 wr_ready = 1'b0;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #500000;
        miscompares++;
        end_of_test();
    end
    initial begin
        cfg_cpol = 1'b0;
        cfg_lsb_first = 1'b1;
        cfg_status_en = 1'b1;
        rd_valid = 1'b1;
        rd_data = 8'ha5;
        wr_ready = 1'b0;
        modem_rts = 1'b1;
        modem_dtr = 1'b0;
        usb_state = 2'h0;
        rst_n = 1'b0;
        repeat (16) @(posedge core_clk);
        #2 rst_n = 1'b1;
        #320 chk({4'h0, miso_oe, miso_out, data_oe[0], data_out[0]}, 8'h0f);
        chk(data_oe, 8'h01);
        cfg_status_en = 1'b0;
        #320 chk(data_oe | {7'h0, miso_oe}, 8'h00);
        cfg_status_en = 1'b1;
        for (int i = 0; i < 5; i++) u_mst.txb[i] = 8'h5a + 8'(i);
        u_mst.xfer(4'h0, 8, 5, 0);
        for (int i = 0; i < 5; i++) chk(8'(u_mst.akb[i]), 8'(i / 4));
        chk({7'h0, data_out[0]}, 8'h00);
        for (int i = 0; i < 4; i++) pop(8'h5a + 8'(i));
        #320 chk({6'h0, wr_valid, data_out[0]}, 8'h01);
        u_mst.xfer(4'h1, 8, 1, 1);
        got(8'ha5, 1'b0);
        rd_valid = 1'b0;
        u_mst.xfer(4'h1, 8, 1, 1);
        got(8'ha5, 1'b1);
        chk(8'(n_rd), 8'h01);
        u_mst.xfer(4'h2, 8, 1, 1);
        got(8'h01, 1'b0);
        // Command 0x3 holds line 3 low, which already selects four lines or more.
        for (int i = 0; i < 4; i++) begin
            cfg_lsb_first = i[0];
            u_mst.txb[0] = 8'h90 | 8'(3 + 5 * i);
            u_mst.xfer(4'h3, 4 << i[1], 1, 0);
            chk(8'(modem_status), 8'(3 + 5 * i) & 8'h0f);
        end
        u_mst.xfer(4'h4, 8, 0, 0);
        chk(8'(n_fl), 8'h01);
        u_mst.txb[0] = 8'h3c;
        u_mst.xfer(4'h5, 8, 1, 0);
        chk(nv_addr, 8'h3c);
        u_mst.txb[0] = 8'h96;
        u_mst.xfer(4'h6, 8, 1, 0);
        chk(nv_wr_data, 8'h96);
        chk(8'(n_nv), 8'h01);
        for (int i = 0; i < 3; i++) begin
            cfg_lsb_first = i[0];
            u_mst.xfer(4'h7, 1 << i, 1, 1);
            got(8'hc3, 1'b0);
        end
        for (int s = 0; s < 4; s++) begin
            usb_state = 2'(s);
            u_mst.xfer(4'h8, 8, 1, 1);
            got(8'(s), 1'b0);
        end
        u_mst.txb[0] = 8'h00;
        for (int c = 9; c < 16; c++) begin
            u_mst.xfer(4'(c), 8, 1, 0);
            chk(8'(u_mst.akb[0]), 8'h01);
        end
        chk({modem_status, 3'h0, wr_valid}, 8'h20);
        chk(nv_addr, 8'h3c);
        chk(8'(n_fl + n_nv), 8'h02);
        cfg_cpol = 1'b1;
        u_mst.txb[0] = 8'h9a;
        u_mst.xfer(4'h3, 4, 1, 0);
        chk(8'(modem_status), 8'h0a);
        end_of_test();
    end
endmodule // vwsp_slave_bench
`default_nettype wire
